/* File: core/adc_cal_map.svh */
// Constants for the multi-device calibration and status core.
// Assumes a 50 MHz core clock that is the host-supplied master clock.
// Function
// [RULE1] Host drives one identical master clock into every converter.
// [RULE2] Host strobes all sync/reset pins together at least once to align sampling.
// [RULE3] Converter answers on the shared bus only while its chip select is low.
// [RULE4] Serial data output stays high impedance while chip select is high.
// [RULE5] Host never selects two converters sharing the data line at once.
// [RULE6] Offset calibration value is subtracted from every conversion result.
// [RULE7] Offset-corrected result is multiplied by the gain calibration factor.
// [RULE8] Host writes reciprocal of measured gain into gain calibration registers.
// [RULE9] Pulse format with unread data updates output buffer every other conversion.
// [RULE10] Host reads data after every ready falling edge for full rate.
// [RULE11] Resync flag sets again whenever sync toggles out of step with timing.
// [RULE12] Sync pin is a continuous timing check, never a conversion start.
// [RULE13] Same frame is presented until every word of it was read.
// [RULE14] Host reads every word of the frame, disabled channels included.
// [RULE15] Configuration write sets fault flag until barrier transfer completes.
// [RULE16] Host polls fault flag to zero before collecting conversion data.
`ifndef ADC_CAL_MAP_SVH
`define ADC_CAL_MAP_SVH

`define CORE_CLK_NS       20
`define BARRIER_XFER_NS   1280
`define BARRIER_XFER_CYC  7'((`BARRIER_XFER_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
`define SAMPLE_LAST       8'hFF
`define CONVERSION_READY_PIN_PULSE_CYC    3'h4
`define FRAME_LAST        6'h2F
`define STAT_RESYNC_BIT   23
`define STAT_FAULT_BIT    22
`define GAIN_ONE          24'h800000
`define GAIN_HALF         24'h400000
`define GAIN_FRAC_BITS    23
`define SAT_POS           24'h7FFFFF
`define SAT_NEG           24'h800000

`endif

/* File: core/adc_cal_pkg.sv */
// Types shared by the calibration and status core.
// Constants live in adc_cal_map.svh.
package adc_cal_pkg;

  typedef logic [23:0] sample_t;

  typedef struct packed {
    logic [15:0] offset_cal_high;
    logic [7:0]  offset_cal_low;
    logic [15:0] gain_cal_high;
    logic [7:0]  gain_cal_low;
  } cal_s;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sync_n;
  } pins_s;

  typedef enum logic [1:0] {
    SPI_IDLE  = 2'b00,
    SPI_SHIFT = 2'b01,
    SPI_DONE  = 2'b10
  } spi_e;

endpackage

/* File: core/adc_cal_corrector.sv */
// Two-stage offset subtract and gain multiply on each conversion result.
// Assumes samples and calibration values arrive on the core clock.
`timescale 1ns/1ns
`include "adc_cal_map.svh"
module adc_cal_corrector
  import adc_cal_pkg::*;
(
  // Clock and reset
  input  wire logic    i_core_clk,
  input  wire logic    i_rst,
  // Raw conversion and calibration values
  input  wire logic    i_conv_valid,
  input  wire sample_t i_conv_data,
  input  wire cal_s    i_cal,
  // Corrected result
  output logic         o_valid,
  output sample_t      o_data
);

  wire sample_t            offset = {i_cal.offset_cal_high, i_cal.offset_cal_low};
  wire sample_t            gain   = {i_cal.gain_cal_high, i_cal.gain_cal_low};
  wire logic signed [24:0] diff   = $signed({i_conv_data[23], i_conv_data})
                                  - $signed({offset[23], offset});
  logic signed [24:0]      diff_reg;
  sample_t                 gain_reg;
  logic                    v1_reg;

  // Gain is an unsigned 1.23 fraction, so 24'h800000 passes data unchanged
  wire logic signed [49:0] product = diff_reg * $signed({1'b0, gain_reg});
  wire logic        [26:0] scaled  = product[49:`GAIN_FRAC_BITS];
  wire logic               fits    = (scaled[26:23] == {4{scaled[23]}});
  wire sample_t            sat     = fits ? scaled[23:0] : (scaled[26] ? `SAT_NEG : `SAT_POS);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      diff_reg <= '0;
      gain_reg <= `GAIN_ONE;
      v1_reg   <= 1'b0;
      o_valid  <= 1'b0;
      o_data   <= '0;
    end else begin
      diff_reg <= diff;  // [RULE6]
      gain_reg <= gain;
      v1_reg   <= i_conv_valid;
      o_valid  <= v1_reg;
      if (v1_reg) begin
        o_data <= sat;  // [RULE7]
      end
    end
  end

  // Helper terms for the checks below
  wire logic    diff_fit = (diff[24] == diff[23]);
  wire sample_t half_in  = diff[24:1];

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  a_offset_subtract: assert property ( // [RULE6]
    i_conv_valid && gain == `GAIN_ONE && diff_fit |-> ##2 o_valid && o_data == $past(diff[23:0], 2))
    else $error("offset not subtracted");
  a_gain_half: assert property ( // [RULE7]
    i_conv_valid && gain == `GAIN_HALF |-> ##2 o_data == $past(half_in, 2))
    else $error("gain factor not applied");
  a_result_latency: assert property ( // [RULE7]
    i_conv_valid && !v1_reg |-> ##1 !o_valid ##1 o_valid)
    else $error("corrected result latency wrong");

endmodule

/* File: core/adc_multi_device_cal_status.sv */
// Host-facing core of one isolated converter on a shared serial bus.
// Runs on the host master clock; serial pins and sync are asynchronous
// to it and are synchronised first. Conversion results come from the
// modulator pipeline on the same clock.
`timescale 1ns/1ns
`include "adc_cal_map.svh"
module adc_multi_device_cal_status
  import adc_cal_pkg::*;
(
  // Clock and reset
  input  wire logic    i_core_clk,
  input  wire logic    i_rst,
  // Host serial pins
  input  wire logic    i_sclk,
  input  wire logic    i_cs_n,
  output logic         o_dout,
  output logic         o_dout_oe_n,
  // Timing pins
  input  wire logic    i_sync_reset_n,
  output logic         o_conversion_ready_pin_n,
  // Conversion pipeline
  input  wire logic    i_conv_valid,
  input  wire sample_t i_conv_data,
  output logic         o_sample_strobe,
  // Configuration
  input  wire logic    i_ready_pulse_format,
  input  wire cal_s    i_cal,
  input  wire logic    i_cfg_write,
  // Status
  output logic         o_resync_flag,
  output logic         o_isolated_side_fault_flag,
  output logic         o_frame_unread
);

  // Pin synchronisers: meta stage feeds only the second stage
  wire pins_s  pin_raw = '{sclk: i_sclk, cs_n: i_cs_n, sync_n: i_sync_reset_n};
  pins_s       meta_reg;
  pins_s       pin_reg;
  pins_s       prev_reg;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= '{sclk: 1'b0, cs_n: 1'b1, sync_n: 1'b1};
      pin_reg  <= '{sclk: 1'b0, cs_n: 1'b1, sync_n: 1'b1};
      prev_reg <= '{sclk: 1'b0, cs_n: 1'b1, sync_n: 1'b1};
    end else begin
      meta_reg <= pin_raw;
      pin_reg  <= meta_reg;
      prev_reg <= pin_reg;
    end
  end

  wire logic cs_low    = ~pin_reg.cs_n;
  wire logic cs_fall   = ~pin_reg.cs_n & prev_reg.cs_n;
  wire logic sclk_fall = ~pin_reg.sclk & prev_reg.sclk;
  wire logic sync_fall = ~pin_reg.sync_n & prev_reg.sync_n;

  // Sample timing; the sync pin only realigns it, never starts a conversion
  logic [7:0] phase_reg;
  wire  logic out_of_step = sync_fall && (phase_reg != 8'h00);
  wire  logic [7:0] phase_next = (sync_fall || phase_reg == `SAMPLE_LAST) ? 8'h00
                                                                        : phase_reg + 8'h01;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_reg       <= 8'h00;
      o_sample_strobe <= 1'b0;
    end else begin
      phase_reg       <= phase_next;  // [RULE12]
      o_sample_strobe <= (phase_next == 8'h00);
    end
  end

  // Calibration
  logic    corr_valid;
  sample_t corr_data;

  adc_cal_corrector u_corrector (
    .i_core_clk   (i_core_clk),
    .i_rst        (i_rst),
    .i_conv_valid (i_conv_valid),
    .i_conv_data  (i_conv_data),
    .i_cal        (i_cal),
    .o_valid      (corr_valid),
    .o_data       (corr_data)
  );

  // Output buffer; results arriving mid-read wait so the frame stays whole
  sample_t buf_reg;
  sample_t pend_data_reg;
  logic    pending_reg;
  logic    skip_reg;
  logic    consumed;
  wire logic    new_valid = ~cs_low & (corr_valid | pending_reg);
  wire sample_t new_data  = corr_valid ? corr_data : pend_data_reg;
  wire logic    take      = new_valid & (~i_ready_pulse_format | ~o_frame_unread | skip_reg);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      buf_reg        <= '0;
      pend_data_reg  <= '0;
      pending_reg    <= 1'b0;
      skip_reg       <= 1'b0;
      o_frame_unread <= 1'b0;
    end else begin
      pending_reg <= cs_low & (pending_reg | corr_valid);
      if (corr_valid) begin
        pend_data_reg <= corr_data;
      end
      if (new_valid) begin
        skip_reg <= i_ready_pulse_format & o_frame_unread & ~skip_reg;  // [RULE9]
      end
      if (take) begin
        buf_reg <= new_data;  // [RULE9]
      end
      if (take) begin
        o_frame_unread <= 1'b1;
      end else if (consumed) begin
        o_frame_unread <= 1'b0;  // [RULE13]
      end
    end
  end

  // Ready pin: pulse in pulse format, level until chip select falls otherwise
  logic [2:0] pulse_cnt_reg;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_conversion_ready_pin_n <= 1'b1;
      pulse_cnt_reg            <= 3'h0;
    end else if (take) begin
      o_conversion_ready_pin_n <= 1'b0;
      pulse_cnt_reg            <= `CONVERSION_READY_PIN_PULSE_CYC;
    end else begin
      if (pulse_cnt_reg != 3'h0) begin
        pulse_cnt_reg <= pulse_cnt_reg - 3'h1;
      end
      if (cs_fall || (i_ready_pulse_format && pulse_cnt_reg == 3'h1)) begin
        o_conversion_ready_pin_n <= 1'b1;
      end
    end
  end

  // Serial frame: status word then data word, MSB first
  spi_e        state_reg;
  logic [47:0] shift_reg;
  logic [5:0]  bit_cnt_reg;
  wire  logic [23:0] status_word = {o_resync_flag, o_isolated_side_fault_flag, 22'h0};
  assign consumed = (state_reg == SPI_SHIFT) && cs_low && sclk_fall
                  && (bit_cnt_reg == `FRAME_LAST);
  assign o_dout   = shift_reg[47];

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg   <= SPI_IDLE;
      shift_reg   <= '0;
      bit_cnt_reg <= 6'h00;
      o_dout_oe_n <= 1'b1;
    end else begin
      o_dout_oe_n <= ~cs_low;  // [RULE4]
      case (state_reg)
        SPI_IDLE: begin
          if (cs_fall) begin
            state_reg   <= SPI_SHIFT;  // [RULE3]
            shift_reg   <= {status_word, buf_reg};
            bit_cnt_reg <= 6'h00;
          end
        end
        SPI_SHIFT: begin
          if (!cs_low) begin
            state_reg <= SPI_IDLE;  // [RULE13]
          end else if (sclk_fall) begin
            shift_reg   <= {shift_reg[46:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
            if (consumed) begin
              state_reg <= SPI_DONE;
            end
          end
        end
        SPI_DONE: begin
          if (!cs_low) begin
            state_reg <= SPI_IDLE;
          end
        end
        default: begin
          state_reg <= SPI_IDLE;
        end
      endcase
    end
  end

  // Status flags; a new event wins over the clear in the same cycle
  logic [6:0] fault_cnt_reg;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_resync_flag              <= 1'b0;
      o_isolated_side_fault_flag <= 1'b0;
      fault_cnt_reg              <= 7'h00;
    end else begin
      if (out_of_step) begin
        o_resync_flag <= 1'b1;  // [RULE11]
      end else if (consumed) begin
        o_resync_flag <= 1'b0;
      end
      if (i_cfg_write) begin
        o_isolated_side_fault_flag <= 1'b1;  // [RULE15]
        fault_cnt_reg              <= `BARRIER_XFER_CYC;
      end else if (fault_cnt_reg != 7'h00) begin
        fault_cnt_reg <= fault_cnt_reg - 7'h01;
        if (fault_cnt_reg == 7'h01) begin
          o_isolated_side_fault_flag <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence s_read_abandoned;
    state_reg == SPI_SHIFT && !cs_low;
  endsequence
  sequence s_frame_held;
    o_frame_unread && state_reg == SPI_IDLE;
  endsequence

  a_dout_hiz: assert property ( // [RULE4]
    pin_reg.cs_n |=> o_dout_oe_n)
    else $error("data output driven while deselected");
  a_quiet_deselect: assert property ( // [RULE3]
    pin_reg.cs_n && state_reg != SPI_SHIFT |=> $stable(shift_reg) && state_reg != SPI_SHIFT)
    else $error("responded while deselected");
  a_half_rate: assert property ( // [RULE9]
    new_valid && i_ready_pulse_format && o_frame_unread && !skip_reg
      |=> $stable(buf_reg) && skip_reg)
    else $error("buffer updated on skipped conversion");
  a_frame_held: assert property ( // [RULE13]
    o_frame_unread ##0 s_read_abandoned |=> s_frame_held)
    else $error("partly read frame dropped");
  a_resync_set: assert property ( // [RULE11]
    out_of_step |=> o_resync_flag)
    else $error("resync flag not set");
  a_sync_realign: assert property ( // [RULE12]
    sync_fall |=> phase_reg == 8'h00 ##1 phase_reg == 8'h01)
    else $error("sample timing not realigned");
  a_fault_set: assert property ( // [RULE15]
    i_cfg_write |=> o_isolated_side_fault_flag && fault_cnt_reg == `BARRIER_XFER_CYC)
    else $error("fault flag not raised by write");
  a_fault_release: assert property ( // [RULE15]
    $fell(o_isolated_side_fault_flag) |-> $past(fault_cnt_reg) == 7'h01)
    else $error("fault flag cleared early");

endmodule

/* File: verif/spi_host_model.sv */
// Host model: serial controller and sync strobe for one converter.
// Assumes the bench feeds it the converter's own master clock.
`timescale 1ns/1ns
module spi_host_model (
  // Clock
  input  wire logic i_core_clk,
  // Data line as seen on the board
  input  wire logic i_dout_line,
  // Pins to the converter
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sync_reset_n
);
  // Link clock idles low outside frames
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sync_reset_n = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  // Only this converter is ever selected on the line
  task automatic read_bits(input int n, output logic [47:0] word);
    word = '0;
    tick(1);
    o_cs_n = 1'b0;
    tick(6);
    for (int k = 0; k < n; k++) begin
      o_sclk = 1'b1;
      tick(4);
      o_sclk = 1'b0;
      word = {word[46:0], i_dout_line};
      tick(4);
    end
    tick(4);
    o_cs_n = 1'b1;
    tick(6);
  endtask

  // Shared clock and one common strobe align the devices
  task automatic sync_strobe();
    tick(1);
    o_sync_reset_n = 1'b0;
    tick(4);
    o_sync_reset_n = 1'b1;
  endtask
endmodule

/* File: verif/adc_multi_device_cal_status_test.sv */
// Self-checking bench for the calibration and status core.
// Assumes the core files compile first; one converter on the line.
`timescale 1ns/1ns
`include "adc_cal_map.svh"
module adc_multi_device_cal_status_test
  import adc_cal_pkg::*;
;
  logic        i_core_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_conv_valid = 1'b0;
  logic        i_ready_pulse_format = 1'b0;
  logic        i_cfg_write = 1'b0;
  sample_t     i_conv_data = '0;
  cal_s        i_cal = '0;
  logic        sclk, cs_n, sync_n, dout, oe_n, ready_n, resync, fault, unread, strobe;
  logic        last_bit = 1'b0;
  logic        rdy_q = 1'b1;
  wire         line;
  logic [47:0] f;
  int          fails = 0;
  int          checked = 0;
  int          falls = 0;
  int          base;
  int          strobes = 0;
  sample_t     raw_r  [5] = '{24'h000064, 24'h000064, 24'hFFFF9C, 24'h7FFFFF, 24'h800000};
  sample_t     off_r  [5] = '{24'h00000A, 24'h000000, 24'h000000, 24'hFFFFFF, 24'h000001};
  sample_t     gain_r [5] = '{`GAIN_ONE, `GAIN_HALF, 24'hC00000, 24'hC00000, `GAIN_ONE};
  sample_t     exp_r  [5] = '{24'h00005A, 24'h000032, 24'hFFFF6A, `SAT_POS, `SAT_NEG};

  initial forever #10 i_core_clk = ~i_core_clk;

  // Released line shows the inverse of its last bit, never a stale match
  always @(posedge i_core_clk) if (!oe_n) last_bit <= dout;
  assign line = oe_n ? ~last_bit : dout;

  always @(posedge i_core_clk) begin
    rdy_q <= ready_n;
    if (rdy_q && !ready_n) falls <= falls + 1;
  end

  always @(posedge i_core_clk) if (strobe === 1'b1) strobes <= strobes + 1;

  adc_multi_device_cal_status i_dut (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n),
    .o_dout(dout), .o_dout_oe_n(oe_n), .i_sync_reset_n(sync_n),
    .o_conversion_ready_pin_n(ready_n), .i_conv_valid(i_conv_valid),
    .i_conv_data(i_conv_data), .o_sample_strobe(strobe),
    .i_ready_pulse_format(i_ready_pulse_format),
    .i_cal(i_cal), .i_cfg_write(i_cfg_write), .o_resync_flag(resync),
    .o_isolated_side_fault_flag(fault), .o_frame_unread(unread));

  spi_host_model i_host (
    .i_core_clk(i_core_clk), .i_dout_line(line), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_sync_reset_n(sync_n));

  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic convert(input sample_t raw);
    i_conv_data = raw;
    i_conv_valid = 1'b1;
    tick(1);
    i_conv_valid = 1'b0;
  endtask

  task automatic get_frame(output logic [47:0] w);
    int n;
    n = 0;
    while (fault !== 1'b0 && n < 200) begin
      tick(1);
      n++;
    end
    if (fault !== 1'b0) begin
      fails++;
      $display("[ERR] %0t fault flag stuck", $time);
      print_verdict();
    end
    i_host.read_bits(48, w);
  endtask

  initial begin
    repeat (8) @(posedge i_core_clk);
    #1 i_rst = 1'b0;
    check(oe_n === 1'b1 && ready_n === 1'b1 && unread === 1'b0, "reset outputs");
    check(resync === 1'b0 && fault === 1'b0, "reset flags");
    $display("test reset done");
    i_host.sync_strobe();
    tick(6);
    check(resync === 1'b1, "resync not set");
    check(unread === 1'b0 && ready_n === 1'b1, "sync started a conversion");
    check(strobes == 1, "sample timing not realigned");
    get_frame(f);
    check(f[47:46] === 2'b10 && resync === 1'b0, "resync status");
    tick(90);
    i_host.sync_strobe();
    tick(6);
    check(resync === 1'b1, "resync not set again");
    get_frame(f);
    $display("test sync done");
    for (int r = 0; r < 5; r++) begin
      i_cal = {off_r[r], gain_r[r]};
      convert(raw_r[r]);
      tick(3);
      check(ready_n === 1'b0 && oe_n === 1'b1, "ready or line");
      get_frame(f);
      check(f === {24'h000000, exp_r[r]}, "frame");
      check(unread === 1'b0 && oe_n === 1'b1, "frame kept");
    end
    $display("test rows done");
    i_cal = {24'h000000, `GAIN_ONE};
    convert(24'h000123);
    tick(4);
    i_host.read_bits(20, f);
    check(unread === 1'b1, "partial read consumed");
    get_frame(f);
    check(f[23:0] === 24'h000123 && unread === 1'b0, "repeat frame");
    $display("test partial done");
    // Result landing mid-read must wait until the frame is released
    fork
      get_frame(f);
      begin
        tick(30);
        convert(24'h000456);
      end
    join
    check(f[23:0] === 24'h000123 && unread === 1'b1, "mid-read result");
    get_frame(f);
    check(f[23:0] === 24'h000456 && unread === 1'b0, "held result");
    $display("test midread done");
    i_cfg_write = 1'b1;
    tick(1);
    i_cfg_write = 1'b0;
    check(fault === 1'b1, "fault not set");
    tick(30);
    i_cfg_write = 1'b1;
    tick(1);
    i_cfg_write = 1'b0;
    tick(59);
    check(fault === 1'b1, "fault not restarted");
    tick(6);
    check(fault === 1'b0, "fault stuck");
    $display("test fault done");
    i_ready_pulse_format = 1'b1;
    base = falls;
    for (int k = 0; k < 4; k++) begin
      convert(24'h000010 + 24'(k));
      tick(20);
    end
    check(falls - base == 2, "ready rate");
    get_frame(f);
    check(f[23:0] === 24'h000012, "pulse data");
    $display("test pulse done");
    print_verdict();
  end
endmodule
